/* File: core/fiml_fault_interrupt_mask_latch.sv */
// Fault mask registers, clock/boost latch, channel summary and interrupt gating
// Functional notes
// - Bit 7 at 0x32 masks positive-input overvoltage
// - Bit 6 masks negative overvoltage; 5..0 reserved
// - 0x33 bits 7,6 mask monitor thresholds
// - 0x33 bits 5,4 mask voice detect; reset 0x30
// - 0x33 bits 3..0 mask bias faults
// - 0x34 bit 7 latches clock error
// - 0x34 bits 6..3 latch PLL, boost events
// - 0x35 bits 7,6 summarise channel faults
// - 0x35 bit 3 flags low-battery short
// - Clock error paired with mask at 0x2F
// - Summary derived from per-channel fault latches
`timescale 1ns/1ps
`include "fiml_params.svh"
module fiml_fault_interrupt_mask_latch
    import fiml_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control port register access
    input wire fiml_req_t regReq,
    output logic [7:0] rdData,
    output logic rdValid,
    // Event pulses from clock, PLL and boost logic
    input wire fiml_evt_t evtIn,
    // Fault levels from other monitors
    input wire logic [1:0] overVoltageFault,
    input wire logic [7:0] thresholdBiasFault,
    // Per-channel latched input fault registers
    input wire logic [7:0] ch1FaultLatch,
    input wire logic [7:0] ch2FaultLatch,
    input wire logic batteryBelowBias,
    // Interrupt request, active high
    output logic intReq
);

    logic [7:0] clkMask_r;
    logic [7:0] ovMask_r;
    logic [7:0] thrMask_r;
    logic [7:0] latch_r;
    logic [7:0] summary_r;
    logic [7:0] evtVec;
    logic [7:0] summaryNow;
    logic rdLatch;
    logic rdSummary;
    logic batLowEvt;
    fiml_rd_state_t rdState_r;

    // Address match helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign rdLatch = regReq.rdEn && hit(regReq.addr, `FIML_OFS_CLK_LATCH);
    assign rdSummary = regReq.rdEn && hit(regReq.addr, `FIML_OFS_CH_SUMMARY);

    // Event vector in latch bit order
    always_comb
    begin
        evtVec = 8'h00;
        evtVec[`FIML_BIT_CLK_ERR] = evtIn.clkErr;
        evtVec[`FIML_BIT_PLL_LOCK] = evtIn.pllLock;
        evtVec[`FIML_BIT_BST_OT] = evtIn.boostOverTemp;
        evtVec[`FIML_BIT_BST_OC] = evtIn.boostOverCurrent;
        evtVec[`FIML_BIT_BST_MODE] = evtIn.boostModeEvent;
    end

    // Summary sources from per-channel latches
    assign batLowEvt = batteryBelowBias && (ch1FaultLatch[`FIML_CH_BAT_POS] || ch1FaultLatch[`FIML_CH_BAT_NEG]
        || ch2FaultLatch[`FIML_CH_BAT_POS] || ch2FaultLatch[`FIML_CH_BAT_NEG]);
    always_comb
    begin
        summaryNow = 8'h00;
        summaryNow[`FIML_BIT_SUM_CH1] = |ch1FaultLatch;
        summaryNow[`FIML_BIT_SUM_CH2] = |ch2FaultLatch;
        summaryNow[`FIML_BIT_SUM_BAT_LOW] = batLowEvt;
    end

    // Mask register writes, reserved bits held at zero
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            clkMask_r <= `FIML_RST_CLK_MASK;
            ovMask_r <= `FIML_RST_OV_MASK;
            thrMask_r <= `FIML_RST_THR_MASK;
        end
        else if (regReq.wrEn)
        begin
            if (hit(regReq.addr, `FIML_OFS_CLK_MASK))
                clkMask_r <= regReq.wrData & `FIML_CLK_MASK_USED;
            if (hit(regReq.addr, `FIML_OFS_OV_MASK))
                ovMask_r <= regReq.wrData & `FIML_OV_MASK_USED;
            if (hit(regReq.addr, `FIML_OFS_THR_MASK))
                thrMask_r <= regReq.wrData;
        end
    end

    // Sticky latch, cleared on read; a new event wins over the clear
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            latch_r <= `FIML_RST_LATCH;
        else if (rdLatch)
            latch_r <= evtVec;
        else
            latch_r <= latch_r | evtVec;
    end

    // Summary sticky, cleared on read
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            summary_r <= `FIML_RST_LATCH;
        else if (rdSummary)
            summary_r <= summaryNow;
        else
            summary_r <= summary_r | summaryNow;
    end

    // Read data path, registered, unmapped reads return zero
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rdData <= 8'h00;
            rdState_r <= FIML_RD_IDLE;
        end
        else
        begin
            rdState_r <= regReq.rdEn ? FIML_RD_DONE : FIML_RD_IDLE;
            if (regReq.rdEn)
            begin
                case (regReq.addr)
                    `FIML_OFS_CLK_MASK: rdData <= clkMask_r;
                    `FIML_OFS_OV_MASK: rdData <= ovMask_r;
                    `FIML_OFS_THR_MASK: rdData <= thrMask_r;
                    `FIML_OFS_CLK_LATCH: rdData <= latch_r & `FIML_LATCH_USED;
                    `FIML_OFS_CH_SUMMARY: rdData <= summary_r & `FIML_SUM_USED;
                    default: rdData <= 8'h00;
                endcase
            end
        end
    end
    assign rdValid = (rdState_r == FIML_RD_DONE);

    // Interrupt: unmasked latched events and unmasked live faults
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            intReq <= 1'b0;
        else
            intReq <= |(latch_r & ~clkMask_r & `FIML_LATCH_USED)
                || |({overVoltageFault, 6'h00} & ~ovMask_r & `FIML_OV_MASK_USED)
                || |(thresholdBiasFault & ~thrMask_r);
    end

    // Helper sequences for assertions
    sequence s_latch_read;
        rdLatch && !evtVec[`FIML_BIT_CLK_ERR];
    endsequence
    sequence s_clk_event;
        evtIn.clkErr;
    endsequence

    a_clk_err_latch: assert property (@(posedge core_clk) disable iff (rst)
        s_clk_event |=> latch_r[`FIML_BIT_CLK_ERR])
        else $error("clock error not latched");
    a_latch_read_clear: assert property (@(posedge core_clk) disable iff (rst)
        s_latch_read |=> !latch_r[`FIML_BIT_CLK_ERR])
        else $error("clock error latch not cleared on read");
    a_pll_latch_hold: assert property (@(posedge core_clk) disable iff (rst)
        latch_r[`FIML_BIT_PLL_LOCK] && !rdLatch |=> latch_r[`FIML_BIT_PLL_LOCK])
        else $error("PLL latch lost without read");
    a_ov_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
        (ovMask_r & ~`FIML_OV_MASK_USED) == 8'h00)
        else $error("overvoltage mask reserved bits set");
    a_ov_pos_write: assert property (@(posedge core_clk) disable iff (rst)
        regReq.wrEn && hit(regReq.addr, `FIML_OFS_OV_MASK) |=> ovMask_r[7] == $past(regReq.wrData[7]))
        else $error("positive overvoltage mask not written");
    a_thr_write: assert property (@(posedge core_clk) disable iff (rst)
        regReq.wrEn && hit(regReq.addr, `FIML_OFS_THR_MASK) |=> thrMask_r == $past(regReq.wrData))
        else $error("threshold mask not written");
    a_vad_masked: assert property (@(posedge core_clk) disable iff (rst)
        thrMask_r[5] && thrMask_r[4] && (thresholdBiasFault & ~8'h30) == 8'h00 && latch_r == 8'h00
        && overVoltageFault == 2'b00 |=> !intReq)
        else $error("masked voice detect raised interrupt");
    a_bias_unmasked: assert property (@(posedge core_clk) disable iff (rst)
        thresholdBiasFault[0] && !thrMask_r[0] |=> intReq)
        else $error("unmasked bias fault no interrupt");
    a_clk_mask_gate: assert property (@(posedge core_clk) disable iff (rst)
        latch_r[7] && !clkMask_r[7] |=> intReq)
        else $error("unmasked clock error no interrupt");
    a_summary_ch1: assert property (@(posedge core_clk) disable iff (rst)
        |ch1FaultLatch |=> summary_r[`FIML_BIT_SUM_CH1])
        else $error("channel 1 summary missed");
    a_summary_bat: assert property (@(posedge core_clk) disable iff (rst)
        batteryBelowBias && ch2FaultLatch[1] |=> summary_r[`FIML_BIT_SUM_BAT_LOW])
        else $error("battery low summary missed");
    a_read_latency: assert property (@(posedge core_clk) disable iff (rst)
        regReq.rdEn && hit(regReq.addr, `FIML_OFS_CLK_LATCH) |=> rdValid && (rdData & 8'h07) == 8'h00)
        else $error("latch read reserved bits nonzero");

    // Write and read strobes per register
    sequence s_ov_mask_write;
        regReq.wrEn && hit(regReq.addr, `FIML_OFS_OV_MASK);
    endsequence
    sequence s_thr_mask_write;
        regReq.wrEn && hit(regReq.addr, `FIML_OFS_THR_MASK);
    endsequence
    sequence s_clk_mask_write;
        regReq.wrEn && hit(regReq.addr, `FIML_OFS_CLK_MASK);
    endsequence
    sequence s_summary_read;
        rdSummary;
    endsequence
    sequence s_pll_in_read;
        rdLatch && evtIn.pllLock;
    endsequence

    // Mask writes land, reserved bits stay zero
    a_ov_neg_write: assert property (@(posedge core_clk) disable iff (rst)
        s_ov_mask_write |=> ovMask_r[`FIML_BIT_OV_NEG] == $past(regReq.wrData[`FIML_BIT_OV_NEG]))
        else $error("negative overvoltage mask not written");
    a_clk_mask_write: assert property (@(posedge core_clk) disable iff (rst)
        s_clk_mask_write |=> clkMask_r == ($past(regReq.wrData) & `FIML_CLK_MASK_USED))
        else $error("clock mask not written");
    a_clk_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
        (clkMask_r & ~`FIML_CLK_MASK_USED) == 8'h00)
        else $error("clock mask reserved bits set");
    a_latch_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
        (latch_r & ~`FIML_LATCH_USED) == 8'h00)
        else $error("latch reserved bits set");

    // Live overvoltage faults pass when unmasked
    a_ov_pos_pass: assert property (@(posedge core_clk) disable iff (rst)
        overVoltageFault[1] && !ovMask_r[`FIML_BIT_OV_POS] |=> intReq)
        else $error("unmasked positive overvoltage no interrupt");
    a_ov_neg_pass: assert property (@(posedge core_clk) disable iff (rst)
        overVoltageFault[0] && !ovMask_r[`FIML_BIT_OV_NEG] |=> intReq)
        else $error("unmasked negative overvoltage no interrupt");

    // Threshold, voice detect and bias faults pass when unmasked
    a_thr_upper_pass: assert property (@(posedge core_clk) disable iff (rst)
        thresholdBiasFault[7] && !thrMask_r[7] |=> intReq)
        else $error("unmasked upper threshold no interrupt");
    a_thr_lower_pass: assert property (@(posedge core_clk) disable iff (rst)
        thresholdBiasFault[6] && !thrMask_r[6] |=> intReq)
        else $error("unmasked lower threshold no interrupt");
    a_vad_up_pass: assert property (@(posedge core_clk) disable iff (rst)
        thresholdBiasFault[5] && !thrMask_r[5] |=> intReq)
        else $error("unmasked voice power up no interrupt");
    a_vad_down_pass: assert property (@(posedge core_clk) disable iff (rst)
        thresholdBiasFault[4] && !thrMask_r[4] |=> intReq)
        else $error("unmasked voice power down no interrupt");
    a_bias_short_pass: assert property (@(posedge core_clk) disable iff (rst)
        thresholdBiasFault[3] && !thrMask_r[3] |=> intReq)
        else $error("unmasked bias short no interrupt");
    a_bias_high_pass: assert property (@(posedge core_clk) disable iff (rst)
        thresholdBiasFault[2] && !thrMask_r[2] |=> intReq)
        else $error("unmasked bias high current no interrupt");
    a_bias_low_pass: assert property (@(posedge core_clk) disable iff (rst)
        thresholdBiasFault[1] && !thrMask_r[1] |=> intReq)
        else $error("unmasked bias low current no interrupt");

    // Every clock and boost event source latches
    a_pll_event_latch: assert property (@(posedge core_clk) disable iff (rst)
        evtIn.pllLock |=> latch_r[`FIML_BIT_PLL_LOCK])
        else $error("PLL event not latched");
    a_bst_ot_latch: assert property (@(posedge core_clk) disable iff (rst)
        evtIn.boostOverTemp |=> latch_r[`FIML_BIT_BST_OT])
        else $error("boost over temperature not latched");
    a_bst_oc_latch: assert property (@(posedge core_clk) disable iff (rst)
        evtIn.boostOverCurrent |=> latch_r[`FIML_BIT_BST_OC])
        else $error("boost over current not latched");
    a_bst_mode_latch: assert property (@(posedge core_clk) disable iff (rst)
        evtIn.boostModeEvent |=> latch_r[`FIML_BIT_BST_MODE])
        else $error("boost mode event not latched");

    // Set wins over read clear; fully masked sources stay quiet
    a_latch_set_wins: assert property (@(posedge core_clk) disable iff (rst)
        s_pll_in_read |=> latch_r[`FIML_BIT_PLL_LOCK])
        else $error("event lost in read cycle");
    a_masked_quiet: assert property (@(posedge core_clk) disable iff (rst)
        (latch_r & ~clkMask_r & `FIML_LATCH_USED) == 8'h00 && (thresholdBiasFault & ~thrMask_r) == 8'h00
        && ({overVoltageFault, 6'h00} & ~ovMask_r) == 8'h00 |=> !intReq)
        else $error("masked sources raised interrupt");

    // Summary channel 2, clear on read, battery gate and reserved bits
    a_summary_ch2: assert property (@(posedge core_clk) disable iff (rst)
        |ch2FaultLatch |=> summary_r[`FIML_BIT_SUM_CH2])
        else $error("channel 2 summary missed");
    a_summary_clear: assert property (@(posedge core_clk) disable iff (rst)
        rdSummary && summaryNow == 8'h00 |=> summary_r == 8'h00)
        else $error("summary not cleared on read");
    a_bat_gate: assert property (@(posedge core_clk) disable iff (rst)
        rdSummary && !batteryBelowBias |=> !summary_r[`FIML_BIT_SUM_BAT_LOW])
        else $error("battery low summary without low battery");
    a_summary_resv: assert property (@(posedge core_clk) disable iff (rst)
        s_summary_read |=> rdValid && (rdData & ~`FIML_SUM_USED) == 8'h00)
        else $error("summary read reserved bits nonzero");
endmodule

/* File: include/fiml_params.svh */
// Offsets, field positions, reset values and widths of the fault mask and latch block
`ifndef FIML_PARAMS_SVH
`define FIML_PARAMS_SVH
`define FIML_ADDR_W 8
`define FIML_OFS_CLK_MASK 8'h2F
`define FIML_OFS_OV_MASK 8'h32
`define FIML_OFS_THR_MASK 8'h33
`define FIML_OFS_CLK_LATCH 8'h34
`define FIML_OFS_CH_SUMMARY 8'h35
`define FIML_RST_CLK_MASK 8'hF8
`define FIML_RST_OV_MASK 8'h00
`define FIML_RST_THR_MASK 8'h30
`define FIML_RST_LATCH 8'h00
`define FIML_OV_MASK_USED 8'hC0
`define FIML_CLK_MASK_USED 8'hF8
`define FIML_LATCH_USED 8'hF8
`define FIML_SUM_USED 8'hC8
`define FIML_BIT_CLK_ERR 7
`define FIML_BIT_PLL_LOCK 6
`define FIML_BIT_BST_OT 5
`define FIML_BIT_BST_OC 4
`define FIML_BIT_BST_MODE 3
`define FIML_BIT_SUM_CH1 7
`define FIML_BIT_SUM_CH2 6
`define FIML_BIT_SUM_BAT_LOW 3
`define FIML_BIT_OV_POS 7
`define FIML_BIT_OV_NEG 6
`define FIML_CH_BAT_POS 1
`define FIML_CH_BAT_NEG 0
`endif

/* File: include/fiml_pkg.sv */
// Types shared by the fault mask and latch block
package fiml_pkg;
    // Register port request from the control interface
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } fiml_req_t;
    // Event pulses for the clock and boost latch
    typedef struct packed {
        logic clkErr;
        logic pllLock;
        logic boostOverTemp;
        logic boostOverCurrent;
        logic boostModeEvent;
    } fiml_evt_t;
    // Read response state, valid pulse one cycle after a read
    typedef enum logic [0:0] {
        FIML_RD_IDLE = 1'b0,
        FIML_RD_DONE = 1'b1
    } fiml_rd_state_t;
endpackage

/* File: testbench/tb_top.sv */
// Register-level self-checking bench for the fault mask and latch block
`timescale 1ns/1ps
`include "fiml_params.svh"
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
    import fiml_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    fiml_req_t regReq = '0;
    fiml_evt_t evtIn = '0;
    logic [1:0] overVoltageFault = 2'b00;
    logic [7:0] thresholdBiasFault = 8'h00;
    logic [7:0] ch1FaultLatch = 8'h00;
    logic [7:0] ch2FaultLatch = 8'h00;
    logic batteryBelowBias = 1'b0;
    logic [7:0] rdData;
    logic rdValid;
    logic intReq;
    int errors = 0;
    int numChecks = 0;
    fiml_fault_interrupt_mask_latch u_fiml_fault_interrupt_mask_latch (.core_clk(core_clk), .rst(rst),
        .regReq(regReq), .rdData(rdData), .rdValid(rdValid), .evtIn(evtIn), .overVoltageFault(overVoltageFault),
        .thresholdBiasFault(thresholdBiasFault), .ch1FaultLatch(ch1FaultLatch), .ch2FaultLatch(ch2FaultLatch),
        .batteryBelowBias(batteryBelowBias), .intReq(intReq));
    // Free-running control clock
    initial
    begin
        forever #25 core_clk = ~core_clk;
    end
    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One register write, taken at the second edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
        @(posedge core_clk);
        regReq <= '0;
    endtask
    // One register read, compared when rdValid pulses
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        int n;
        n = 0;
        @(posedge core_clk);
        regReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
        @(posedge core_clk);
        regReq <= '0;
        #1;
        while (rdValid !== 1'b1 && n < 4)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (rdValid !== 1'b1)
        begin
            errors++;
            finish_test();
        end
        `CHK(nm, e, rdData)
    endtask
    // Let inputs propagate to the registered interrupt, then compare it
    task automatic irq(input logic e, input string nm);
        repeat (3) @(posedge core_clk);
        #1;
        `CHK(nm, e, intReq)
    endtask
    // One-cycle event pulse, driven at rising edges
    task automatic pulseEvt(input logic [4:0] v);
        @(posedge core_clk);
        evtIn <= fiml_evt_t'(v);
        @(posedge core_clk);
        evtIn <= '0;
    endtask
    // One-cycle pulse on the per-channel latch inputs
    task automatic pulseCh(input logic [7:0] c1, input logic [7:0] c2, input logic bat);
        @(posedge core_clk);
        ch1FaultLatch <= c1;
        ch2FaultLatch <= c2;
        batteryBelowBias <= bat;
        @(posedge core_clk);
        ch1FaultLatch <= 8'h00;
        ch2FaultLatch <= 8'h00;
        batteryBelowBias <= 1'b0;
    endtask
    // Main sequence; reserved bits are always written as zero
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        rd(`FIML_OFS_CLK_MASK, `FIML_RST_CLK_MASK, "rst2F");
        rd(`FIML_OFS_OV_MASK, 8'h00, "rst32");
        rd(`FIML_OFS_THR_MASK, 8'h30, "rst33");
        rd(`FIML_OFS_CLK_LATCH, 8'h00, "rst34");
        rd(`FIML_OFS_CH_SUMMARY, 8'h00, "rst35");
        rd(8'h40, 8'h00, "unmapped");
        irq(1'b0, "irqIdle");
        wr(`FIML_OFS_OV_MASK, 8'hC0);
        rd(`FIML_OFS_OV_MASK, 8'hC0, "rw32");
        wr(`FIML_OFS_CLK_LATCH, 8'hF8);
        rd(`FIML_OFS_CLK_LATCH, 8'h00, "ro34");
        $display("test registers done");
        // Overvoltage sources, each passed, crossed and masked
        for (int i = 0; i < 2; i++)
        begin
            @(posedge core_clk);
            overVoltageFault <= 2'b10 >> i;
            wr(`FIML_OFS_OV_MASK, 8'h00);
            irq(1'b1, "ovPass");
            wr(`FIML_OFS_OV_MASK, 8'h40 << i);
            irq(1'b1, "ovCross");
            wr(`FIML_OFS_OV_MASK, 8'h80 >> i);
            irq(1'b0, "ovMask");
        end
        @(posedge core_clk);
        overVoltageFault <= 2'b00;
        // Threshold, voice detect and bias sources
        for (int i = 0; i < 8; i++)
        begin
            @(posedge core_clk);
            thresholdBiasFault <= 8'h01 << i;
            wr(`FIML_OFS_THR_MASK, ~(8'h01 << i));
            irq(1'b1, "thrPass");
            wr(`FIML_OFS_THR_MASK, 8'hFF);
            irq(1'b0, "thrMask");
        end
        @(posedge core_clk);
        thresholdBiasFault <= 8'h00;
        rd(`FIML_OFS_THR_MASK, 8'hFF, "rw33");
        $display("test live faults done");
        // Each clock and boost event latches, interrupts, clears on read
        wr(`FIML_OFS_CLK_MASK, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            pulseEvt(5'b10000 >> i);
            irq(1'b1, "evtIrq");
            rd(`FIML_OFS_CLK_LATCH, 8'h80 >> i, "evtLatch");
            rd(`FIML_OFS_CLK_LATCH, 8'h00, "evtClear");
            irq(1'b0, "evtIrqGone");
        end
        wr(`FIML_OFS_CLK_MASK, 8'hF8);
        rd(`FIML_OFS_CLK_MASK, 8'hF8, "rw2F");
        pulseEvt(5'b10000);
        irq(1'b0, "evtMasked");
        rd(`FIML_OFS_CLK_LATCH, 8'h80, "maskedLatch");
        // An event standing through the read cycle survives the clear
        @(posedge core_clk);
        evtIn <= fiml_evt_t'(5'b01000);
        rd(`FIML_OFS_CLK_LATCH, 8'h40, "setWins");
        @(posedge core_clk);
        evtIn <= '0;
        rd(`FIML_OFS_CLK_LATCH, 8'h40, "setKept");
        rd(`FIML_OFS_CLK_LATCH, 8'h00, "setClear");
        $display("test events done");
        // Channel summary from per-channel latches, sticky until read
        pulseCh(8'h04, 8'h00, 1'b0);
        rd(`FIML_OFS_CH_SUMMARY, 8'h80, "sumCh1");
        rd(`FIML_OFS_CH_SUMMARY, 8'h00, "sumClear");
        pulseCh(8'h00, 8'h80, 1'b0);
        rd(`FIML_OFS_CH_SUMMARY, 8'h40, "sumCh2");
        rd(`FIML_OFS_CH_SUMMARY, 8'h00, "sumClear2");
        pulseCh(8'h00, 8'h02, 1'b1);
        rd(`FIML_OFS_CH_SUMMARY, 8'h48, "sumBatCh2");
        rd(`FIML_OFS_CH_SUMMARY, 8'h00, "sumClear3");
        pulseCh(8'h01, 8'h00, 1'b1);
        rd(`FIML_OFS_CH_SUMMARY, 8'h88, "sumBatCh1");
        pulseCh(8'h01, 8'h00, 1'b0);
        rd(`FIML_OFS_CH_SUMMARY, 8'h80, "sumBatHigh");
        rd(`FIML_OFS_CH_SUMMARY, 8'h00, "sumEnd");
        $display("test summary done");
        // Mid-run reset restores the mask defaults
        wr(`FIML_OFS_THR_MASK, 8'h00);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(`FIML_OFS_THR_MASK, 8'h30, "rstMid33");
        rd(`FIML_OFS_CLK_MASK, 8'hF8, "rstMid2F");
        rd(`FIML_OFS_OV_MASK, 8'h00, "rstMid32");
        irq(1'b0, "irqRst");
        $display("test reset done");
        finish_test();
    end
endmodule
